// file: common/uocs_defines.svh
`ifndef UOCS_DEFINES_SVH
`define UOCS_DEFINES_SVH
// Register offsets (byte addresses, chosen)
`define UOCS_OFF_STATUS   8'h00
`define UOCS_OFF_CONTROL  8'h04
`define UOCS_OFF_ADDRESS  8'h08
`define UOCS_OFF_IRQSTAT  8'h0c
// Status view fields
`define UOCS_STAT_EP_HI   7
`define UOCS_STAT_EP_LO   4
`define UOCS_STAT_DIR     3
`define UOCS_STAT_ODD     2
// Control fields
`define UOCS_CON_JLINE    7
`define UOCS_CON_SE0      6
`define UOCS_CON_HOLD     5
`define UOCS_CON_BUSRST   4
`define UOCS_CON_HOST_CAPABILITY_ENABLE   3
`define UOCS_CON_RESUME   2
`define UOCS_CON_PPRST    1
`define UOCS_CON_EN       0
// Address fields
`define UOCS_ADDR_LS      7
// Interrupt status bit for transaction complete
`define UOCS_IRQ_TRN      3
// Reset values
`define UOCS_CON_RESET    8'h00
`define UOCS_ADDR_RESET   8'h00
// Timing
`define UOCS_CLK_MHZ      100
`define UOCS_FRAME_US     1000
`define UOCS_FRAME_CYC    (`UOCS_FRAME_US * `UOCS_CLK_MHZ)
// Queue
`define UOCS_QDEPTH       4
`endif

// file: common/uocs_pkg.sv
package uocs_pkg;
	typedef struct packed {
		logic [3:0] endpoint;
		logic       tx_dir;
		logic       odd_bank;
	} uocs_rec_t;
	typedef enum logic [1:0] {
		UOCS_RS_IDLE,
		UOCS_RS_SIGNAL,
		UOCS_RS_EOP
	} uocs_resume_t;
endpackage : uocs_pkg

// file: common/uocs_q_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uocs_q_if;
	logic               push;
	uocs_pkg::uocs_rec_t push_rec;
	logic               pop;
	logic               not_empty;
	logic               full;
	uocs_pkg::uocs_rec_t head;
	modport owner (output push, output push_rec, output pop,
		input not_empty, input full, input head);
	modport queue (input push, input push_rec, input pop,
		output not_empty, output full, output head);
endinterface : uocs_q_if
`default_nettype wire

// file: src/uocs_status_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "uocs_defines.svh"
module uocs_status_queue (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Queue port
	uocs_q_if.queue   q
);
	uocs_pkg::uocs_rec_t mem_reg [0:`UOCS_QDEPTH-1];
	logic [1:0]          rd_reg;
	logic [1:0]          wr_reg;
	logic [2:0]          cnt_reg;
	wire                 do_pop;
	wire                 do_push;

	assign do_pop  = q.pop && (cnt_reg != 3'h0);
	// Full queue drops the new record so unread ones survive
	assign do_push = q.push && (cnt_reg != 3'h4);
	assign q.not_empty = (cnt_reg != 3'h0);
	assign q.full      = (cnt_reg == 3'h4);
	assign q.head      = mem_reg[rd_reg];

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rd_reg  <= 2'h0;
			wr_reg  <= 2'h0;
			cnt_reg <= 3'h0;
		end
		else
		begin
			if (do_push)
			begin
				mem_reg[wr_reg] <= q.push_rec;
				wr_reg          <= wr_reg + 2'h1;
			end
			if (do_pop)
				rd_reg <= rd_reg + 2'h1;
			cnt_reg <= cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
		end
	end

	a_queue_bound: assert property (@(posedge mclk) disable iff (!rst_n)
		cnt_reg <= 3'h4) else $error("queue count over depth");
	a_full_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.full && q.push && !q.pop) |=> q.full) else $error("full queue lost state");
endmodule : uocs_status_queue
`default_nettype wire

// file: src/uocs_control_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "uocs_defines.svh"
// Contract
// - status bits 7:4 hold last endpoint
// - status bit 3 one for transmit
// - status bit 2 one for odd bank
// - status view is head of four-deep queue
// - view valid only while complete flag set
// - clearing complete flag pops the queue
// - unimplemented bits read zero
// - control bit 7 shows live J state
// - control bit 6 shows live SE0
// - device SETUP sets hold until cleared
// - host bit 5 shows token busy
// - toggling host enable resets host logic
// - host appends low-speed EOP at resume end
// - bit 1 forces pointers to even bank
// - device bit 0 enables module
// - host bit 0 sends SOF every ms
// - address bit 7 selects low speed
// - 7-bit device address, resets zero
module uocs_control_status (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [31:0] reg_rdata,
	// Line state pins
	input  wire logic       line_j_pin,
	input  wire logic       line_se0_pin,
	// Transaction engine
	input  wire logic       txn_done,
	input  wire logic [3:0] txn_endpoint,
	input  wire logic       txn_tx,
	input  wire logic       txn_odd,
	input  wire logic       setup_rcvd,
	input  wire logic       token_start,
	input  wire logic       token_end,
	// Control outputs
	output logic            module_enable_device,
	output logic            packet_processing_hold,
	output logic            bus_reset_drive,
	output logic            resume_drive,
	output logic            ls_eop_drive,
	output logic            pingpong_pointer_reset,
	output logic            sof_pulse,
	output logic            host_logic_reset,
	output logic            low_speed_next_token,
	output logic      [6:0] bus_device_address,
	output logic            transaction_complete_flag
);
	uocs_q_if qi ();
	uocs_status_queue u_queue (
		.mclk  (mclk),
		.rst_n (rst_n),
		.q     (qi.queue)
	);

	logic [1:0]  j_sync_reg;
	logic [1:0]  se0_sync_reg;
	logic        hold_reg;
	logic        busy_reg;
	logic        busrst_reg;
	logic        host_capability_enable_reg;
	logic        resume_reg;
	logic        pprst_reg;
	logic        en_reg;
	logic        ls_reg;
	logic [6:0]  addr_reg;
	logic [16:0] sof_cnt_reg;
	logic        sof_reg;
	logic        hrst_reg;
	logic        eop_reg;
	logic        resume_d_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	uocs_pkg::uocs_rec_t rec;

	wire wr_con   = reg_wr && (reg_addr == `UOCS_OFF_CONTROL);
	wire wr_addr  = reg_wr && (reg_addr == `UOCS_OFF_ADDRESS);
	wire wr_irq   = reg_wr && (reg_addr == `UOCS_OFF_IRQSTAT);
	// Write one to clear the complete flag, which pops one record
	wire clr_trn  = wr_irq && reg_wdata[`UOCS_IRQ_TRN];
	wire host     = host_capability_enable_reg;
	wire host_capability_enable_toggle = wr_con && (reg_wdata[`UOCS_CON_HOST_CAPABILITY_ENABLE] != host_capability_enable_reg);
	wire bit5_rd  = host ? busy_reg : hold_reg;
	wire j_live   = j_sync_reg[1];
	wire se0_live = se0_sync_reg[1];
	wire sof_wrap = (sof_cnt_reg == 17'(`UOCS_FRAME_CYC - 1));

	assign qi.push     = txn_done;
	assign qi.push_rec = '{endpoint: txn_endpoint, tx_dir: txn_tx, odd_bank: txn_odd};
	assign qi.pop      = clr_trn;
	assign rec         = qi.head;

	// An empty queue reads as zero rather than a stale record
	wire [31:0] stat_word = qi.not_empty ?
		{24'h000000,
		rec.endpoint,
		rec.tx_dir,
		rec.odd_bank,
		2'h0} : 32'h00000000;
	wire [31:0] con_word = {24'h000000, j_live, se0_live, bit5_rd, busrst_reg,
		host_capability_enable_reg, resume_reg, pprst_reg, en_reg};
	wire [31:0] addr_word = {24'h000000, ls_reg, addr_reg};
	wire [31:0] irq_word  = {28'h0000000, qi.not_empty, 3'h0};

	always_comb
	begin
		rdata_next = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				`UOCS_OFF_STATUS:  rdata_next = stat_word;
				`UOCS_OFF_CONTROL: rdata_next = con_word;
				`UOCS_OFF_ADDRESS: rdata_next = addr_word;
				`UOCS_OFF_IRQSTAT: rdata_next = irq_word;
				default:           rdata_next = 32'h00000000;
			endcase
		end
	end

	// Pin inputs cross into mclk through two flops
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			j_sync_reg   <= 2'h0;
			se0_sync_reg <= 2'h0;
			rdata_reg    <= 32'h00000000;
		end
		else
		begin
			j_sync_reg   <= {j_sync_reg[0], line_j_pin};
			se0_sync_reg <= {se0_sync_reg[0], line_se0_pin};
			rdata_reg    <= rdata_next;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			hold_reg   <= 1'b0;
			busrst_reg <= 1'b0;
			host_capability_enable_reg <= 1'b0;
			resume_reg <= 1'b0;
			pprst_reg  <= 1'b0;
			en_reg     <= 1'b0;
			ls_reg     <= 1'b0;
			addr_reg   <= 7'h00;
		end
		else
		begin
			if (wr_con)
			begin
				busrst_reg <= reg_wdata[`UOCS_CON_BUSRST];
				host_capability_enable_reg <= reg_wdata[`UOCS_CON_HOST_CAPABILITY_ENABLE];
				resume_reg <= reg_wdata[`UOCS_CON_RESUME];
				pprst_reg  <= reg_wdata[`UOCS_CON_PPRST];
				en_reg     <= reg_wdata[`UOCS_CON_EN];
			end
			// SETUP arrival wins over a simultaneous software clear
			if (!host && setup_rcvd)
				hold_reg <= 1'b1;
			else if (wr_con && !host)
				hold_reg <= reg_wdata[`UOCS_CON_HOLD];
			if (wr_addr)
			begin
				ls_reg   <= reg_wdata[`UOCS_ADDR_LS];
				addr_reg <= reg_wdata[6:0];
			end
		end
	end

	// Host side logic, cleared whenever host enable toggles
	always_ff @(posedge mclk)
	begin
		if (!rst_n || hrst_reg)
		begin
			busy_reg     <= 1'b0;
			sof_cnt_reg  <= 17'h00000;
			sof_reg      <= 1'b0;
			eop_reg      <= 1'b0;
			resume_d_reg <= 1'b0;
		end
		else
		begin
			if (host && token_start)
				busy_reg <= 1'b1;
			else if (token_end)
				busy_reg <= 1'b0;
			sof_reg <= 1'b0;
			if (host && en_reg)
			begin
				sof_cnt_reg <= sof_wrap ? 17'h00000 : sof_cnt_reg + 17'h00001;
				sof_reg     <= sof_wrap;
			end
			else
				sof_cnt_reg <= 17'h00000;
			resume_d_reg <= resume_reg;
			eop_reg      <= host && resume_d_reg && !resume_reg;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			hrst_reg <= 1'b0;
		else
			hrst_reg <= host_capability_enable_toggle;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			module_enable_device      <= 1'b0;
			packet_processing_hold    <= 1'b0;
			bus_reset_drive           <= 1'b0;
			resume_drive              <= 1'b0;
			pingpong_pointer_reset    <= 1'b0;
			low_speed_next_token      <= 1'b0;
			bus_device_address        <= 7'h00;
			transaction_complete_flag <= 1'b0;
		end
		else
		begin
			module_enable_device      <= !host && en_reg;
			packet_processing_hold    <= !host && hold_reg;
			bus_reset_drive           <= host && busrst_reg;
			resume_drive              <= resume_reg;
			pingpong_pointer_reset    <= pprst_reg;
			low_speed_next_token      <= ls_reg;
			bus_device_address        <= addr_reg;
			transaction_complete_flag <= qi.not_empty;
		end
	end

	assign reg_rdata        = rdata_reg;
	assign sof_pulse        = sof_reg;
	assign ls_eop_drive     = eop_reg;
	assign host_logic_reset = hrst_reg;

	// Frame timer counts only while host and frame start are both on
	a_sof_period: assert property (@(posedge mclk) disable iff (!rst_n || hrst_reg)
		(host && en_reg && !sof_wrap) |=>
		(!sof_reg && sof_cnt_reg == $past(sof_cnt_reg) + 17'h00001))
		else $error("frame counter did not advance");
	a_sof_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		!(host && en_reg) |=> (!sof_reg && sof_cnt_reg == 17'h00000))
		else $error("frame timer running while off");

	// Packet hold and token busy share bit five, split by mode
	a_hold_sets: assert property (@(posedge mclk) disable iff (!rst_n)
		(!host && setup_rcvd) |=> hold_reg)
		else $error("hold not set on setup");
	a_hold_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		(hold_reg && !(wr_con && !host)) |=> hold_reg)
		else $error("hold dropped without a write");
	a_hold_out: assert property (@(posedge mclk) disable iff (!rst_n)
		host |=> !packet_processing_hold)
		else $error("hold shown in host mode");
	a_busy_track: assert property (@(posedge mclk) disable iff (!rst_n || hrst_reg)
		(host && token_start) |=> busy_reg)
		else $error("busy not set");
	a_busy_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(token_end && !(host && token_start)) |=> !busy_reg)
		else $error("busy not cleared");

	// Bus reset, host logic reset and the end of resume
	a_busrst_out: assert property (@(posedge mclk) disable iff (!rst_n)
		(host && busrst_reg) |=> bus_reset_drive)
		else $error("bus reset not driven");
	a_busrst_dev: assert property (@(posedge mclk) disable iff (!rst_n)
		!(host && busrst_reg) |=> !bus_reset_drive)
		else $error("bus reset driven while off");
	a_host_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		host_capability_enable_toggle |=> hrst_reg ##1 !busy_reg)
		else $error("host logic not reset");
	a_host_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
		!host_capability_enable_toggle |=> !hrst_reg)
		else $error("host reset without toggle");
	a_eop_fall: assert property (@(posedge mclk) disable iff (!rst_n || hrst_reg)
		(host && resume_d_reg && !resume_reg) |=> eop_reg)
		else $error("eop missing");
	a_eop_device: assert property (@(posedge mclk) disable iff (!rst_n)
		!host |=> !eop_reg)
		else $error("eop outside host mode");

	// Live line flags, plain output copies and the mode-gated module enable
	a_j_live: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `UOCS_OFF_CONTROL) |=>
		reg_rdata[`UOCS_CON_JLINE] == $past(j_live))
		else $error("j flag not live");
	a_se0_live: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `UOCS_OFF_CONTROL) |=>
		reg_rdata[`UOCS_CON_SE0] == $past(se0_live))
		else $error("se0 flag not live");
	a_pprst_out: assert property (@(posedge mclk) disable iff (!rst_n)
		pprst_reg |=> pingpong_pointer_reset)
		else $error("pointer reset not driven");
	a_enable_out: assert property (@(posedge mclk) disable iff (!rst_n)
		(!host && en_reg) |=> module_enable_device)
		else $error("module enable not driven");
	a_ls_out: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_addr |=> ##1 low_speed_next_token == $past(reg_wdata[`UOCS_ADDR_LS], 2))
		else $error("speed select not driven");

	// Read data
	a_stat_read: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `UOCS_OFF_STATUS) |=>
		(reg_rdata[31:8] == 24'h000000 && reg_rdata[1:0] == 2'h0))
		else $error("status upper bits set");
	a_stat_empty: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `UOCS_OFF_STATUS && !qi.not_empty) |=>
		reg_rdata == 32'h00000000)
		else $error("status shown while empty");
	a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 32'h00000000)
		else $error("read data without a read");
	a_con_upper: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `UOCS_OFF_CONTROL) |=>
		reg_rdata[31:8] == 24'h000000)
		else $error("control upper bits set");
	a_addr_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_addr |=> addr_reg == $past(reg_wdata[6:0]))
		else $error("address not stored");

	// Status queue
	a_flag_pop: assert property (@(posedge mclk) disable iff (!rst_n)
		(clr_trn && !txn_done && qi.not_empty) |=> ##1
		transaction_complete_flag == $past(qi.not_empty))
		else $error("flag not tracking");
	a_pop_frees: assert property (@(posedge mclk) disable iff (!rst_n)
		(clr_trn && !txn_done && qi.full) |=> !qi.full)
		else $error("clear did not pop");
	a_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
		txn_done |=> ##1 transaction_complete_flag)
		else $error("flag not set after transaction");
endmodule : uocs_control_status
`default_nettype wire

// file: tb/uocs_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module uocs_bus_partner (
	// Clock
	input  wire logic       mclk,
	// Bus line levels
	output logic            line_j_pin,
	output logic            line_se0_pin,
	// Transaction events
	output logic            txn_done,
	output logic      [3:0] txn_endpoint,
	output logic            txn_tx,
	output logic            txn_odd,
	output logic            setup_rcvd,
	output logic            token_start,
	output logic            token_end
);
	initial
	begin
		{line_j_pin, line_se0_pin, txn_done} = 3'h0;
		{setup_rcvd, token_start, token_end} = 3'h0;
		{txn_endpoint, txn_tx, txn_odd} = 6'h2a;
	end
	task automatic set_line(input logic j, input logic se0);
		@(posedge mclk);
		line_j_pin   <= j;
		line_se0_pin <= se0;
	endtask : set_line
	// Record lines show the inverse outside the pulse, so stale data never matches
	task automatic txn(input logic [5:0] rec);
		@(posedge mclk);
		txn_done <= 1'b1;
		{txn_endpoint, txn_tx, txn_odd} <= rec;
		@(posedge mclk);
		txn_done <= 1'b0;
		{txn_endpoint, txn_tx, txn_odd} <= ~rec;
	endtask : txn
	// 0 setup token, 1 token start, 2 token end
	task automatic pulse(input int sel);
		@(posedge mclk);
		case (sel)
			0: setup_rcvd <= 1'b1;
			1: token_start <= 1'b1;
			default: token_end <= 1'b1;
		endcase
		@(posedge mclk);
		{setup_rcvd, token_start, token_end} <= 3'h0;
	endtask : pulse
endmodule : uocs_bus_partner
`default_nettype wire

// file: tb/usb_otg_control_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uocs_defines.svh"
module usb_otg_control_status_tb_top;
	localparam logic [7:0] sta_a = `UOCS_OFF_STATUS;
	localparam logic [7:0] ctl_a = `UOCS_OFF_CONTROL;
	localparam logic [7:0] adr_a = `UOCS_OFF_ADDRESS;
	localparam logic [7:0] irq_a = `UOCS_OFF_IRQSTAT;
	logic        mclk, rst_n, reg_wr, reg_rd, line_j_pin, line_se0_pin, txn_done, txn_tx;
	logic        txn_odd, setup_rcvd, token_start, token_end, module_enable_device;
	logic        packet_processing_hold, bus_reset_drive, resume_drive, ls_eop_drive;
	logic        pingpong_pointer_reset, sof_pulse, host_logic_reset, low_speed_next_token;
	logic        transaction_complete_flag;
	logic [3:0]  txn_endpoint;
	logic [6:0]  bus_device_address;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	int          fail_count = 0;
	int          compares = 0;
	uocs_control_status dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.line_j_pin(line_j_pin), .line_se0_pin(line_se0_pin), .txn_done(txn_done),
		.txn_endpoint(txn_endpoint), .txn_tx(txn_tx), .txn_odd(txn_odd),
		.setup_rcvd(setup_rcvd), .token_start(token_start), .token_end(token_end),
		.module_enable_device(module_enable_device),
		.packet_processing_hold(packet_processing_hold), .bus_reset_drive(bus_reset_drive),
		.resume_drive(resume_drive), .ls_eop_drive(ls_eop_drive),
		.pingpong_pointer_reset(pingpong_pointer_reset), .sof_pulse(sof_pulse),
		.host_logic_reset(host_logic_reset), .low_speed_next_token(low_speed_next_token),
		.bus_device_address(bus_device_address),
		.transaction_complete_flag(transaction_complete_flag));
	uocs_bus_partner partner (.mclk(mclk), .line_j_pin(line_j_pin),
		.line_se0_pin(line_se0_pin), .txn_done(txn_done), .txn_endpoint(txn_endpoint),
		.txn_tx(txn_tx), .txn_odd(txn_odd), .setup_rcvd(setup_rcvd),
		.token_start(token_start), .token_end(token_end));
	always #5 mclk = ~mclk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(n, e, reg_rdata);
	endtask : rd
	// 0 waits for the host reset pulse, 1 for the low-speed end of packet
	// First look is just after the write's own edge: the reset pulse lasts one cycle
	task automatic wait_for(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			#1;
			if ((sel == 0) ? (host_logic_reset === 1'b1) : (ls_eop_drive === 1'b1))
				break;
			@(posedge mclk);
		end
		compares++;
		if (i == lim)
		begin
			$display("wrong value pulse %0d expected 1 seen 0", sel);
			fail_count++;
			final_report();
		end
	endtask : wait_for
	task automatic t_reset;
		wr(8'h10, 32'hffffffff);
		rd("unmapped", 8'h10, 32'h0);
		rd("status", sta_a, 32'h0);
		rd("control", ctl_a, 32'h0);
		rd("address", adr_a, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_address;
		wr(adr_a, 32'hffffffff);
		rd("address", adr_a, 32'hff);
		chk("low_speed", 32'h1, {31'h0, low_speed_next_token});
		chk("dev_addr", 32'h7f, {25'h0, bus_device_address});
		wr(adr_a, 32'h35);
		rd("address", adr_a, 32'h35);
		chk("low_speed", 32'h0, {31'h0, low_speed_next_token});
		$display("test address done");
	endtask : t_address
	task automatic t_queue;
		logic [5:0] recs [5] = '{6'h3e, 6'h01, 6'h17, 6'h28, 6'h0f};
		int         k;
		for (k = 0; k < 5; k++)
			partner.txn(recs[k]);
		for (k = 0; k < 4; k++)
		begin
			rd("status", sta_a, {24'h0, recs[k], 2'b00});
			rd("irq", irq_a, 32'h8);
			chk("flag", 32'h1, {31'h0, transaction_complete_flag});
			wr(irq_a, 32'h8);
		end
		rd("irq", irq_a, 32'h0);
		rd("status", sta_a, 32'h0);
		chk("flag", 32'h0, {31'h0, transaction_complete_flag});
		$display("test queue done");
	endtask : t_queue
	task automatic t_lines;
		int k;
		for (k = 0; k < 3; k++)
		begin
			partner.set_line(k == 0, k == 1);
			repeat (4) @(posedge mclk);
			rd("lines", ctl_a, {24'h0, k == 0, k == 1, 6'h0});
		end
		$display("test lines done");
	endtask : t_lines
	task automatic t_device;
		wr(ctl_a, 32'h3);
		rd("control", ctl_a, 32'h3);
		chk("enable", 32'h1, {31'h0, module_enable_device});
		chk("pp_reset", 32'h1, {31'h0, pingpong_pointer_reset});
		partner.pulse(0);
		rd("control", ctl_a, 32'h23);
		chk("hold", 32'h1, {31'h0, packet_processing_hold});
		wr(ctl_a, 32'h1);
		rd("control", ctl_a, 32'h1);
		chk("hold", 32'h0, {31'h0, packet_processing_hold});
		chk("pp_reset", 32'h0, {31'h0, pingpong_pointer_reset});
		$display("test device done");
	endtask : t_device
	task automatic t_host;
		wr(ctl_a, 32'h8);
		wait_for(0, 4);
		wr(ctl_a, 32'h19);
		rd("control", ctl_a, 32'h19);
		chk("bus_reset", 32'h1, {31'h0, bus_reset_drive});
		chk("enable", 32'h0, {31'h0, module_enable_device});
		chk("sof", 32'h0, {31'h0, sof_pulse});
		partner.pulse(1);
		rd("busy", ctl_a, 32'h39);
		partner.pulse(2);
		rd("busy", ctl_a, 32'h19);
		wr(ctl_a, 32'h0d);
		rd("control", ctl_a, 32'h0d);
		chk("bus_reset", 32'h0, {31'h0, bus_reset_drive});
		chk("resume", 32'h1, {31'h0, resume_drive});
		wr(ctl_a, 32'h09);
		wait_for(1, 6);
		wr(ctl_a, 32'h0);
		wait_for(0, 4);
		$display("test host done");
	endtask : t_host
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial
	begin
		{mclk, rst_n, reg_wr, reg_rd} = 4'h0;
		reg_addr  = 8'h0;
		reg_wdata = 32'h0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_address();
		t_queue();
		t_lines();
		t_device();
		t_host();
		final_report();
	end
endmodule : usb_otg_control_status_tb_top
`default_nettype wire
